// ---- bench/fcrc_checker.sv ----
// Concurrent checks on the ports of the CRC block.
// Assumes a bind onto fcrc_top and a single clock domain.
`timescale 1ns/100ps
module fcrc_checker #(
  parameter logic [31:0] PAGE_BYTES = 32'h0000_1000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic feat_wr,
  input wire fcrc_pkg::fcrc_sel_t feat_sel,
  input wire fcrc_pkg::fcrc_word_t feat_wdata,
  input wire fcrc_pkg::fcrc_sel_t feat_rd_sel,
  input wire fcrc_pkg::fcrc_word_t feat_rdata,
  input wire logic e2e_supported,
  input wire logic op_start,
  input wire logic op_read,
  input wire logic op_busy,
  input wire logic op_done,
  input wire logic op_fail,
  input wire logic in_valid,
  input wire fcrc_pkg::fcrc_byte_t in_data,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire fcrc_pkg::fcrc_byte_t out_data
);
  import fcrc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Offset low word written while idle, then picked for readback.
  sequence s_lo_wr;
    feat_wr && !op_busy && feat_sel == 2'h2 ##1 feat_rd_sel == 2'h2;
  endsequence
  // A start that the block accepts.
  sequence s_start;
    op_start && !op_busy;
  endsequence
  AST_LO_READ: assert property (
    s_lo_wr |=> feat_rdata == $past(feat_wdata, 2))
    else $error("Offset low readback wrong.");
  AST_CAP_FLAG: assert property (
    $past(arst_n) |-> e2e_supported)
    else $error("Capability flag low.");
  AST_START_BUSY: assert property (
    s_start |=> op_busy && !op_fail && !op_done)
    else $error("Start not taken cleanly.");
  AST_DONE_END: assert property (
    op_done |-> !op_busy && $past(op_busy))
    else $error("Done without a running operation.");
  AST_FAIL_IDLE: assert property (
    !op_busy && !op_start |=> $stable(op_fail))
    else $error("Fail flag moved while idle.");
  AST_READY_IDLE: assert property (
    !op_busy |-> !in_ready)
    else $error("Ready while idle.");
  AST_OUT_WINDOW: assert property (
    out_valid |-> op_busy || op_done)
    else $error("Output byte outside an operation.");
  AST_PROG_PASS: assert property (
    out_valid && !op_read |->
      $past(in_valid && in_ready) && out_data == $past(in_data))
    else $error("Program byte not passed on.");
endmodule : fcrc_checker

bind fcrc_top fcrc_checker #(.PAGE_BYTES(PAGE_BYTES)) i_fcrc_checker (
  .clk, .arst_n, .feat_wr, .feat_sel, .feat_wdata, .feat_rd_sel,
  .feat_rdata, .e2e_supported, .op_start, .op_read, .op_busy, .op_done,
  .op_fail, .in_valid, .in_data, .in_ready, .out_valid, .out_data);

// ---- bench/fcrc_host_model.sv ----
// Host controller model: starts operations and streams page bytes.
// Assumes a sink that never stalls and stimulus on the falling edge.
`timescale 1ns/100ps
module fcrc_host_model (
  input wire logic clk,
  output logic op_start,
  output logic op_read,
  output logic in_valid,
  output fcrc_pkg::fcrc_byte_t in_data,
  input wire logic in_ready,
  input wire logic op_done,
  input wire logic out_valid,
  input wire fcrc_pkg::fcrc_byte_t out_data
);
  import fcrc_pkg::*;
  fcrc_byte_t tx [16];
  fcrc_byte_t rx [16];
  int rx_n = 0;
  bit hung = 0;
  // Idle levels at time zero.
  initial begin
    op_start = 0;
    op_read = 0;
    in_valid = 0;
    in_data = 8'h00;
  end
  // Output bytes are gathered at the falling edge, where they are settled.
  always @(negedge clk) begin
    if (out_valid === 1'b1 && rx_n < 16) begin
      rx[rx_n] = out_data;
      rx_n++;
    end
  end
  // Starts one operation and holds each byte until the block takes it.
  task automatic run_op(input logic rd, input int n);
    int i;
    int t;
    i = 0;
    t = 0;
    @(negedge clk);
    rx_n = 0;
    op_start = 1;
    op_read = rd;
    @(negedge clk);
    op_start = 0;
    while (op_done !== 1'b1 && t < 400) begin
      in_valid = (i < n);
      in_data = in_valid ? tx[i] : ~in_data;
      if (in_valid && in_ready === 1'b1) i++;
      @(negedge clk);
      t++;
    end
    in_valid = 0;
    hung = (t >= 400);
  endtask : run_op
endmodule : fcrc_host_model

// ---- bench/fcrc_top_bench.sv ----
// Self-checking bench of the CRC block with a host model on its stream.
// Assumes a 16-byte page, so units of 4 or 8 bytes keep runs short.
`timescale 1ns/100ps
`include "fcrc_regs.svh"
module fcrc_top_bench;
  import fcrc_pkg::*;
  logic clk = 0;
  logic arst_n = 0;
  logic feat_wr = 0;
  fcrc_sel_t feat_sel = 2'h0;
  fcrc_sel_t feat_rd_sel = 2'h0;
  fcrc_word_t feat_wdata = 32'h0;
  fcrc_word_t feat_rdata;
  logic e2e_supported, op_start, op_read, op_busy, op_done, op_fail;
  logic in_valid, in_ready, out_valid;
  fcrc_byte_t in_data, out_data;
  fcrc_byte_t full [16];
  fcrc_byte_t dat [16];
  int nd;
  int fails = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  fcrc_top #(.PAGE_BYTES(32'h0000_0010)) i_fcrc_top (
    .clk, .arst_n, .feat_wr, .feat_sel, .feat_wdata, .feat_rd_sel,
    .feat_rdata, .e2e_supported, .op_start, .op_read, .op_busy, .op_done,
    .op_fail, .in_valid, .in_data, .in_ready, .out_valid, .out_data);
  fcrc_host_model i_fcrc_host_model (.clk, .op_start, .op_read,
    .in_valid, .in_data, .in_ready, .op_done, .out_valid, .out_data);
  // Prints the verdict and ends the run.
  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Compares one value and reports a mismatch.
  task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask : check
  // Feature write and readback on the parallel parameter port.
  task automatic wr_feat(input fcrc_sel_t s, input fcrc_word_t d);
    @(negedge clk);
    feat_wr = 1;
    feat_sel = s;
    feat_wdata = d;
    @(negedge clk);
    feat_wr = 0;
  endtask : wr_feat
  task automatic rd_feat(input fcrc_sel_t s, input fcrc_word_t e);
    @(negedge clk);
    feat_rd_sel = s;
    @(negedge clk);
    check("feat_rdata", e, feat_rdata);
  endtask : rd_feat
  // Host setup of mode, width, unit count and offset before use.
  // configure before use.
  task automatic cfg(input fcrc_word_t p0, input fcrc_word_t cnt,
      input fcrc_word_t off);
    feat_rd_sel = 2'h2;
    wr_feat(2'h0, p0);
    wr_feat(2'h1, cnt);
    wr_feat(2'h3, 32'h0);
    wr_feat(2'h2, off);
  endtask : cfg
  // One byte through a left-aligned CRC register, MSB first.
  function automatic logic [31:0] step(input logic [31:0] c,
      input fcrc_byte_t b, input logic [31:0] p, input logic [31:0] m);
    int k;
    c = c ^ {b, 24'h00_0000};
    for (k = 0; k < 8; k++) c = c[31] ? ((c << 1) ^ p) : (c << 1);
    return c & m;
  endfunction : step
  // Builds the page with CRC fields and the bare data bytes.
  task automatic build(input int w, input int off, input int us);
    logic [31:0] c, m, p;
    int j;
    int q;
    fcrc_byte_t b;
    m = ~(32'hFFFF_FFFF >> (8 * w));
    p = (w == 2) ? `FCRC_POLY_16 : (w == 3) ? `FCRC_POLY_24 : `FCRC_POLY_32;
    nd = 0;
    for (j = 0; j < 16; j++) begin
      q = j % us;
      if (q == 0) c = `FCRC_SEED & m;
      b = 8'h3C + 8'(j * 29);
      if (q >= off && q < off + w) full[j] = c[31 - 8 * (q - off) -: 8];
      else begin
        full[j] = b;
        dat[nd] = b;
        nd++;
        if (q < off) c = step(c, b, p, m);
      end
    end
  endtask : build
  // Runs one operation and compares the output stream and fail flag.
  task automatic op(input logic rd, input bit src_full, input bit exp_full,
      input logic fe);
    int n;
    int k;
    n = exp_full ? 16 : nd;
    for (k = 0; k < 16; k++)
      i_fcrc_host_model.tx[k] = src_full ? full[k] : dat[k];
    i_fcrc_host_model.run_op(rd, src_full ? 16 : nd);
    if (i_fcrc_host_model.hung) begin
      fails++;
      wrap_up();
    end
    @(negedge clk);
    check("out count", n, i_fcrc_host_model.rx_n);
    for (k = 0; k < n; k++)
      check("out byte", exp_full ? full[k] : dat[k],
        i_fcrc_host_model.rx[k]);
    check("op_fail", fe, op_fail);
  endtask : op
  // Main sequence: reset values, check mode, off modes, strip mode.
  initial begin
    int k;
    int w;
    int off;
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    check("e2e_supported", 1, e2e_supported);
    rd_feat(2'h0, 32'h2);
    rd_feat(2'h1, 32'h1);
    rd_feat(2'h2, 32'h0);
    rd_feat(2'h3, 32'h0);
    cfg(32'h0000_00F6, 32'h4, 32'h2);
    rd_feat(2'h0, 32'h6);
    rd_feat(2'h1, 32'h4);
    build(2, 2, 4);
    op(1'b0, 1, 1, 1'b0);
    op(1'b1, 1, 1, 1'b0);
    full[14] = ~full[14];
    op(1'b0, 1, 1, 1'b1);
    op(1'b1, 1, 1, 1'b1);
    wr_feat(2'h3, 32'h1);
    rd_feat(2'h3, 32'h1);
    op(1'b0, 1, 1, 1'b0);
    for (k = 0; k < 2; k++) begin
      cfg({28'h0, 2'(3 * k), 2'h2}, 32'h4, 32'h2);
      op(1'b0, 1, 1, 1'b0);
    end
    for (k = 0; k < 3; k++) begin
      w = k + 2;
      off = k + k / 2;
      cfg({28'h0, `FCRC_MODE_STRIP, 2'(w % 4)}, 32'h2, off);
      build(w, off, 8);
      op(1'b0, 1, 0, 1'b0);
      op(1'b1, 0, 1, 1'b0);
      full[off] = ~full[off];
      op(1'b0, 1, 0, 1'b1);
    end
    wrap_up();
  end
endmodule : fcrc_top_bench

// ---- hdl/fcrc_crc_engine.sv ----
// Byte-wide CRC engine of two, three or four bytes, MSB first.
// Assumes width stays constant while an operation runs.
`timescale 1ns/100ps
`include "fcrc_regs.svh"
module fcrc_crc_engine (
  input wire logic clk,
  input wire logic arst_n,
  fcrc_crc_if.eng crc_io
);
  import fcrc_pkg::*;

  logic [31:0] crc_ff;
  logic [31:0] poly;
  logic [31:0] mask;
  logic [31:0] nxt_crc;
  logic [4:0] rshift;

  always_comb begin
    case (crc_io.nbytes)
      3'h2: begin
        poly = `FCRC_POLY_16;
        mask = 32'hFFFF_0000;
        rshift = 5'h10;
      end
      3'h3: begin
        poly = `FCRC_POLY_24;
        mask = 32'hFFFF_FF00;
        rshift = 5'h08;
      end
      default: begin
        poly = `FCRC_POLY_32;
        mask = 32'hFFFF_FFFF;
        rshift = 5'h00;
      end
    endcase
  end

  // Shifts one byte through the left-aligned register.
  always_comb begin
    nxt_crc = crc_ff ^ {crc_io.data, 24'h000000};
    for (int i = 0; i < 8; i++) begin
      nxt_crc = nxt_crc[31] ? ((nxt_crc << 1) ^ poly) : (nxt_crc << 1);
    end
    nxt_crc = nxt_crc & mask;
  end

  // Clear reseeds the register; a clear beats a byte in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_ff <= `FCRC_SEED;
    end else if (crc_io.clr) begin
      crc_ff <= `FCRC_SEED & mask;
    end else if (crc_io.en) begin
      crc_ff <= nxt_crc;
    end
  end

  // Result is presented right-aligned.
  assign crc_io.crc = crc_ff >> rshift;
endmodule : fcrc_crc_engine

// ---- hdl/fcrc_top.sv ----
// End-to-end CRC protection on the byte stream of a flash page.
// Assumes the host stream and array stream run on clk and that the
// output side always accepts a byte marked valid.
`timescale 1ns/100ps
`include "fcrc_regs.svh"
module fcrc_top #(
  parameter logic [31:0] PAGE_BYTES = 32'h0000_1000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic feat_wr,
  input wire fcrc_pkg::fcrc_sel_t feat_sel,
  input wire fcrc_pkg::fcrc_word_t feat_wdata,
  input wire fcrc_pkg::fcrc_sel_t feat_rd_sel,
  output fcrc_pkg::fcrc_word_t feat_rdata,
  output logic e2e_supported,
  input wire logic op_start,
  input wire logic op_read,
  output logic op_busy,
  output logic op_done,
  output logic op_fail,
  input wire logic in_valid,
  input wire fcrc_pkg::fcrc_byte_t in_data,
  output logic in_ready,
  output logic out_valid,
  output fcrc_pkg::fcrc_byte_t out_data
);
  import fcrc_pkg::*;

  fcrc_crc_if crc_io ();

  logic [3:0] mode_width_ff;
  logic [7:0] unit_count_ff;
  fcrc_word_t unit_size_ff;
  fcrc_word_t offset_lo_ff;
  fcrc_word_t offset_hi_ff;
  fcrc_state_t state_ff;
  logic read_ff;
  fcrc_word_t pos_ff;
  logic [7:0] unit_idx_ff;
  fcrc_word_t feat_rdata_ff;
  logic e2e_supported_ff;
  logic op_done_ff;
  logic op_fail_ff;
  logic in_ready_ff;
  logic out_valid_ff;
  fcrc_byte_t out_data_ff;

  logic [1:0] mode;
  logic [2:0] nbytes;
  logic check_on;
  logic gen_on;
  logic strip_pgm;
  logic in_fld;
  logic take;
  logic emit;
  logic step;
  logic unit_end;
  logic page_end;
  logic mism;
  logic [1:0] fld_idx;
  logic [4:0] sh;
  fcrc_byte_t exp_byte;
  fcrc_word_t nxt_pos;
  fcrc_state_t nxt_state;
  logic nxt_read;

  // Tells whether a byte position falls inside the CRC field.
  function automatic logic fld_at(input fcrc_word_t p,
                                  input fcrc_word_t lo,
                                  input fcrc_word_t hi,
                                  input logic [2:0] nb);
    fcrc_word_t rel;
    rel = p - lo;
    fld_at = (hi == 32'h0000_0000) && (p >= lo) && (rel < {29'h0, nb});
  endfunction : fld_at

  // width from the length code; code zero means four bytes.
  assign mode = mode_width_ff[`FCRC_MODE_MSB:`FCRC_MODE_LSB];
  always_comb begin
    case (mode_width_ff[`FCRC_LEN_MSB:`FCRC_LEN_LSB])
      `FCRC_LEN_2: nbytes = 3'h2;
      `FCRC_LEN_3: nbytes = 3'h3;
      2'h0: nbytes = 3'h4;
      default: nbytes = 3'h2;
    endcase
  end

  // off and reserved codes do nothing; pick the work.
  assign check_on = (mode == `FCRC_MODE_CHECK) ||
                    ((mode == `FCRC_MODE_STRIP) && !read_ff);
  assign gen_on = (mode == `FCRC_MODE_STRIP) && read_ff;
  assign strip_pgm = (mode == `FCRC_MODE_STRIP) && !read_ff;

  // field located at the offset; high word must be zero.
  assign in_fld = (check_on || gen_on) &&
                  fld_at(pos_ff, offset_lo_ff, offset_hi_ff, nbytes);
  assign fld_idx = pos_ff[1:0] - offset_lo_ff[1:0];

  // Expected or regenerated CRC byte, most significant byte first.
  assign sh = 5'({nbytes, 3'h0} - 6'h08 - {1'b0, fld_idx, 3'h0});
  assign exp_byte = 8'(crc_io.crc >> sh);

  // in strip mode on read the CRC bytes are inserted instead of taken.
  assign take = (state_ff == FCRC_RUN) && in_valid && in_ready_ff;
  assign emit = (state_ff == FCRC_RUN) && gen_on && in_fld;
  assign step = take || emit;

  assign unit_end = (pos_ff == (unit_size_ff - 32'h0000_0001));
  assign page_end = unit_end && (unit_idx_ff == (unit_count_ff - 8'h01));

  // compare on program and read, compare on program.
  assign mism = take && check_on && in_fld && (in_data != exp_byte);

  // CRC covers the data bytes before the field of each unit.
  assign crc_io.nbytes = nbytes;
  assign crc_io.data = in_data;
  assign crc_io.en = take && !in_fld;
  assign crc_io.clr = ((state_ff == FCRC_IDLE) && op_start) ||
                      (step && unit_end);

  fcrc_crc_engine i_fcrc_crc_engine (
    .clk(clk),
    .arst_n(arst_n),
    .crc_io(crc_io)
  );

  // Next position, state and direction of the operation.
  always_comb begin
    nxt_pos = pos_ff;
    nxt_state = state_ff;
    nxt_read = read_ff;
    case (state_ff)
      FCRC_IDLE: begin
        if (op_start) begin
          nxt_state = FCRC_RUN;
          nxt_read = op_read;
          nxt_pos = 32'h0000_0000;
        end
      end
      FCRC_RUN: begin
        if (step) begin
          nxt_pos = unit_end ? 32'h0000_0000 : pos_ff + 32'h0000_0001;
          if (page_end) begin
            nxt_state = FCRC_IDLE;
          end
        end
      end
      default: nxt_state = FCRC_IDLE;
    endcase
  end

  // Operation sequencing.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= FCRC_IDLE;
      read_ff <= 1'b0;
      pos_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      read_ff <= nxt_read;
      pos_ff <= nxt_pos;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unit_idx_ff <= 8'h00;
    end else if ((state_ff == FCRC_IDLE) && op_start) begin
      unit_idx_ff <= 8'h00;
    end else if (step && unit_end) begin
      unit_idx_ff <= unit_idx_ff + 8'h01;
    end
  end

  // Input is held off while a regenerated CRC byte goes out.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_ready_ff <= 1'b0;
    end else begin
      in_ready_ff <= (nxt_state == FCRC_RUN) &&
        !((mode == `FCRC_MODE_STRIP) && nxt_read &&
          fld_at(nxt_pos, offset_lo_ff, offset_hi_ff, nbytes));
    end
  end

  // strip mode program drops the CRC bytes; strip mode read carries inserted ones.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= 8'h00;
    end else begin
      out_valid_ff <= step && !(strip_pgm && in_fld);
      out_data_ff <= emit ? exp_byte : in_data;
    end
  end

  // fail flag of the running operation; a mismatch beats the clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_fail_ff <= 1'b0;
    end else if (mism) begin
      op_fail_ff <= 1'b1;
    end else if ((state_ff == FCRC_IDLE) && op_start) begin
      op_fail_ff <= 1'b0;
    end
  end

  // Completion pulse on the last byte of the page.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_done_ff <= 1'b0;
    end else begin
      op_done_ff <= (state_ff == FCRC_RUN) && step && page_end;
    end
  end

  // feature writes, ignored while an operation runs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_width_ff <= `FCRC_MODE_WIDTH_RST;
      unit_count_ff <= `FCRC_UNIT_COUNT_RST;
      unit_size_ff <= PAGE_BYTES;
      offset_lo_ff <= `FCRC_OFFSET_RST;
      offset_hi_ff <= `FCRC_OFFSET_RST;
    end else if (feat_wr && (state_ff == FCRC_IDLE)) begin
      case (feat_sel)
        `FCRC_SEL_MODE_WIDTH: mode_width_ff <= feat_wdata[3:0];
        // unit size worked out once per write; zero counts as one.
        `FCRC_SEL_UNIT_COUNT: begin
          unit_count_ff <= (|feat_wdata[7:0]) ? feat_wdata[7:0] : 8'h01;
          unit_size_ff <= PAGE_BYTES / ((feat_wdata[7:0] == 8'h00) ?
                          32'h0000_0001 : {24'h000000, feat_wdata[7:0]});
        end
        // low and high halves of the offset.
        `FCRC_SEL_OFFSET_LO: offset_lo_ff <= feat_wdata;
        `FCRC_SEL_OFFSET_HI: offset_hi_ff <= feat_wdata;
        default: offset_hi_ff <= offset_hi_ff;
      endcase
    end
  end

  // Feature readback; reserved bits read as zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      feat_rdata_ff <= 32'h0000_0000;
    end else begin
      case (feat_rd_sel)
        `FCRC_SEL_MODE_WIDTH: feat_rdata_ff <= {28'h0000000, mode_width_ff};
        `FCRC_SEL_UNIT_COUNT: feat_rdata_ff <= {24'h000000, unit_count_ff};
        `FCRC_SEL_OFFSET_LO: feat_rdata_ff <= offset_lo_ff;
        default: feat_rdata_ff <= offset_hi_ff;
      endcase
    end
  end

  // capability flag for the parameter page, set after reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      e2e_supported_ff <= 1'b0;
    end else begin
      e2e_supported_ff <= 1'b1;
    end
  end

  assign feat_rdata = feat_rdata_ff;
  assign e2e_supported = e2e_supported_ff;
  assign op_busy = (state_ff == FCRC_RUN);
  assign op_done = op_done_ff;
  assign op_fail = op_fail_ff;
  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;
endmodule : fcrc_top

// ---- shared/fcrc_crc_if.sv ----
// Carrier between the stream control and the CRC engine.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
interface fcrc_crc_if;
  logic clr;
  logic en;
  logic [7:0] data;
  logic [2:0] nbytes;
  logic [31:0] crc;
  modport eng (input clr, input en, input data, input nbytes, output crc);
  modport user (output clr, output en, output data, output nbytes,
    input crc);
endinterface : fcrc_crc_if

// ---- shared/fcrc_pkg.sv ----
// Types shared by the flash end-to-end CRC design files.
// Assumes the constants header is compiled alongside.
package fcrc_pkg;
  typedef logic [31:0] fcrc_word_t;
  typedef logic [1:0] fcrc_sel_t;
  typedef logic [7:0] fcrc_byte_t;
  typedef enum logic {FCRC_IDLE, FCRC_RUN} fcrc_state_t;
endpackage : fcrc_pkg

// ---- shared/fcrc_regs.svh ----
// Constants of the flash end-to-end CRC block: feature parameter
// indices, field positions, mode codes, reset values and polynomials.
// Assumes it is included by its bare name from the design files.
//
// What this block does
// - Every protected sub-page of a page carries a CRC of two to four bytes.
// - The length field gives the CRC width in bytes, legal only as 2, 3 or 4.
// - Mode 00b does no generation or checking, and 11b is reserved.
// - Mode 01b checks the CRC on program and again on read.
// - Mode 10b checks and drops the CRC on program, makes a new one on read.
// - The sub-page count splits the page into units of page size over count.
// - The CRC bytes sit at the set offset in each unit, zero meaning first.
// - The 64-bit CRC offset is split into a low and a high 32-bit parameter.
// - A CRC mismatch sets the fail flag of the same program or read.
// - Support for the protection is shown by a flag the host can discover.
`ifndef FCRC_REGS_SVH
`define FCRC_REGS_SVH

// Feature parameter indices on the configuration port.
`define FCRC_SEL_MODE_WIDTH 2'h0
`define FCRC_SEL_UNIT_COUNT 2'h1
`define FCRC_SEL_OFFSET_LO 2'h2
`define FCRC_SEL_OFFSET_HI 2'h3

// Field positions inside the mode and width parameter.
`define FCRC_LEN_LSB 0
`define FCRC_LEN_MSB 1
`define FCRC_MODE_LSB 2
`define FCRC_MODE_MSB 3

// Mode codes.
`define FCRC_MODE_OFF 2'h0
`define FCRC_MODE_CHECK 2'h1
`define FCRC_MODE_STRIP 2'h2

// Length codes; a code of zero stands for four bytes.
`define FCRC_LEN_2 2'h2
`define FCRC_LEN_3 2'h3

// Reset values.
`define FCRC_MODE_WIDTH_RST 4'h2
`define FCRC_UNIT_COUNT_RST 8'h01
`define FCRC_OFFSET_RST 32'h0000_0000

// Left-aligned polynomials and the CRC seed.
`define FCRC_POLY_16 32'h1021_0000
`define FCRC_POLY_24 32'h864C_FB00
`define FCRC_POLY_32 32'h04C1_1DB7
`define FCRC_SEED 32'hFFFF_FFFF

`endif
